// >>> rtl/dceob_top.sv
// channel enable control and end-of-buffer status with axi4-lite slave
`timescale 1ns/1ps

// What this block does
// - bit n maps to channel n
// - only enabled channels get service requests granted
// - disabling a busy channel aborts its packet
// - disabling rewinds channel to first descriptor
// - writing ones to set register enables channels
// - writing ones to reset register stops channels
// - channel error clears its enable
// - set and reset registers read enable state
// - two transmit channels, upper bits reserved
// - one receive channel, upper bits reserved
// - alerted buffer completion sets end-of-buffer bit
// - end of packet sets bit when enabled
// - backed-up packet is no end of packet
// - bad packet flag sets end-of-buffer bit
// - end-of-buffer bits clear on written ones
// - separate transmit and receive status registers
// - end-of-packet enable lives in config bit 29
// - alerted buffers interrupt regardless of that enable
module dceob_top
  import dceob_pkg::*;
#(
  parameter int TX_CHANS = TX_CHANS_DEF,
  parameter int RX_CHANS = RX_CHANS_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [TX_CHANS-1:0] tx_svc_req,
  input wire logic [TX_CHANS-1:0] tx_xfer_active,
  input wire logic [TX_CHANS-1:0] tx_err_ind,
  input wire logic [TX_CHANS-1:0] tx_buf_done,
  input wire logic [TX_CHANS-1:0] tx_buf_alert,
  input wire logic [TX_CHANS-1:0] tx_last_buf,
  input wire logic [TX_CHANS-1:0] tx_backed_up,
  input wire logic [TX_CHANS-1:0] tx_bad_pkt,
  input wire logic [RX_CHANS-1:0] rx_svc_req,
  input wire logic [RX_CHANS-1:0] rx_xfer_active,
  input wire logic [RX_CHANS-1:0] rx_err_ind,
  input wire logic [RX_CHANS-1:0] rx_buf_done,
  input wire logic [RX_CHANS-1:0] rx_buf_alert,
  input wire logic [RX_CHANS-1:0] rx_last_buf,
  input wire logic [RX_CHANS-1:0] rx_backed_up,
  input wire logic [RX_CHANS-1:0] rx_bad_pkt,
  output logic [TX_CHANS-1:0] tx_svc_grant,
  output logic [TX_CHANS-1:0] tx_chan_active,
  output logic [TX_CHANS-1:0] tx_pkt_abort,
  output logic [TX_CHANS-1:0] tx_desc_rewind,
  output logic [RX_CHANS-1:0] rx_svc_grant,
  output logic [RX_CHANS-1:0] rx_chan_active,
  output logic [RX_CHANS-1:0] rx_pkt_abort,
  output logic [RX_CHANS-1:0] rx_desc_rewind,
  output logic eop_irq_enable,
  output logic tx_eob_irq,
  output logic rx_eob_irq
);

  localparam int NCH = TX_CHANS + RX_CHANS;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // channel counts must fit the low byte lane
  if (TX_CHANS < 1 || TX_CHANS > MAX_CHANS_DIR ||
      RX_CHANS < 1 || RX_CHANS > MAX_CHANS_DIR) begin : g_bad_chans
    $error("dceob_top: channel count out of range");
  end

  // write channel state
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [DATA_W-1:0] w_data_ff;
  logic [STRB_W-1:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_go;
  logic [IDX_MSB-IDX_LSB:0] wr_idx;
  logic wr_hit;
  logic ch_lane;

  // read channel state
  logic rvalid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic ar_fire;
  logic [IDX_MSB-IDX_LSB:0] rd_idx;
  logic [DATA_W-1:0] nxt_rdata;
  logic nxt_rerr;

  // channel state, transmit channels low, receive channels high
  logic [NCH-1:0] en_ff;
  logic [NCH-1:0] eob_ff;
  logic [NCH-1:0] abort_ff;
  logic [NCH-1:0] rewind_ff;
  logic end_of_packet_irq_enable_ff;
  logic [NCH-1:0] nxt_en;
  logic [NCH-1:0] nxt_eob;
  logic [NCH-1:0] set_v;
  logic [NCH-1:0] clr_v;
  logic [NCH-1:0] eob_clr_v;
  logic [NCH-1:0] eob_set_v;
  logic [NCH-1:0] req_v;
  logic [NCH-1:0] xfer_v;
  logic [NCH-1:0] err_v;
  logic [NCH-1:0] done_v;
  logic [NCH-1:0] alert_v;
  logic [NCH-1:0] last_v;
  logic [NCH-1:0] backed_v;
  logic [NCH-1:0] bad_v;
  logic [NCH-1:0] grant_v;
  logic [DATA_W-1:0] wd_ch;

  assign req_v = {rx_svc_req, tx_svc_req};
  assign xfer_v = {rx_xfer_active, tx_xfer_active};
  assign err_v = {rx_err_ind, tx_err_ind};
  assign done_v = {rx_buf_done, tx_buf_done};
  assign alert_v = {rx_buf_alert, tx_buf_alert};
  assign last_v = {rx_last_buf, tx_last_buf};
  assign backed_v = {rx_backed_up, tx_backed_up};
  assign bad_v = {rx_bad_pkt, tx_bad_pkt};

  // axi4-lite write: address and data taken in either order
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign wr_go = aw_got_ff && w_got_ff;
  assign wr_idx = aw_addr_ff[IDX_MSB:IDX_LSB];
  assign ch_lane = w_strb_ff[CH_LANE];
  assign wd_ch = ch_lane ? w_data_ff : '0;
  assign wr_hit = (wr_idx == OFF_TX_EN_SET[IDX_MSB:IDX_LSB]) ||
                  (wr_idx == OFF_TX_EN_CLR[IDX_MSB:IDX_LSB]) ||
                  (wr_idx == OFF_RX_EN_SET[IDX_MSB:IDX_LSB]) ||
                  (wr_idx == OFF_RX_EN_CLR[IDX_MSB:IDX_LSB]) ||
                  (wr_idx == OFF_TX_EOB[IDX_MSB:IDX_LSB]) ||
                  (wr_idx == OFF_RX_EOB[IDX_MSB:IDX_LSB]) ||
                  (wr_idx == OFF_CFG[IDX_MSB:IDX_LSB]);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      w_got_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= DCEOB_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? DCEOB_RESP_OKAY : DCEOB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // write strobes per channel; only the low lane carries channel bits
  always_comb begin
    set_v = '0;
    clr_v = '0;
    eob_clr_v = '0;
    if (wr_go && wr_idx == OFF_TX_EN_SET[IDX_MSB:IDX_LSB]) begin
      set_v[TX_CHANS-1:0] = wd_ch[CH_FIELD_LSB +: TX_CHANS];
    end
    if (wr_go && wr_idx == OFF_RX_EN_SET[IDX_MSB:IDX_LSB]) begin
      set_v[NCH-1:TX_CHANS] = wd_ch[CH_FIELD_LSB +: RX_CHANS];
    end
    if (wr_go && wr_idx == OFF_TX_EN_CLR[IDX_MSB:IDX_LSB]) begin
      clr_v[TX_CHANS-1:0] = wd_ch[CH_FIELD_LSB +: TX_CHANS];
    end
    if (wr_go && wr_idx == OFF_RX_EN_CLR[IDX_MSB:IDX_LSB]) begin
      clr_v[NCH-1:TX_CHANS] = wd_ch[CH_FIELD_LSB +: RX_CHANS];
    end
    if (wr_go && wr_idx == OFF_TX_EOB[IDX_MSB:IDX_LSB]) begin
      eob_clr_v[TX_CHANS-1:0] = wd_ch[CH_FIELD_LSB +: TX_CHANS];
    end
    if (wr_go && wr_idx == OFF_RX_EOB[IDX_MSB:IDX_LSB]) begin
      eob_clr_v[NCH-1:TX_CHANS] = wd_ch[CH_FIELD_LSB +: RX_CHANS];
    end
  end

  // configuration: end-of-packet interrupt enable
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      end_of_packet_irq_enable_ff <= RST_END_OF_PACKET_IRQ_ENABLE;
    end else if (wr_go && wr_idx == OFF_CFG[IDX_MSB:IDX_LSB] &&
                 w_strb_ff[CFG_END_OF_PACKET_IRQ_ENABLE_LANE]) begin
      end_of_packet_irq_enable_ff <= w_data_ff[CFG_END_OF_PACKET_IRQ_ENABLE_BIT];
    end
  end

  assign eop_irq_enable = end_of_packet_irq_enable_ff;

  // per-channel enable, abort, rewind and end-of-buffer logic
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      logic dir_irq;

      // error clear wins over a software set in the same cycle
      assign nxt_en[gi] = (en_ff[gi] | set_v[gi]) & ~clr_v[gi] &
                          ~err_v[gi];
      assign grant_v[gi] = en_ff[gi] & req_v[gi];

      // hardware set wins over a write-one clear
      assign eob_set_v[gi] = bad_v[gi] |
                             (done_v[gi] & alert_v[gi]) |
                             (done_v[gi] & last_v[gi] & ~backed_v[gi] &
                              end_of_packet_irq_enable_ff);
      assign nxt_eob[gi] = eob_set_v[gi] |
                           (eob_ff[gi] & ~eob_clr_v[gi]);

      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          en_ff[gi] <= RST_ENABLE;
        end else begin
          en_ff[gi] <= nxt_en[gi];
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          abort_ff[gi] <= 1'b0;
          rewind_ff[gi] <= 1'b0;
        end else begin
          abort_ff[gi] <= en_ff[gi] & ~nxt_en[gi] & xfer_v[gi];
          rewind_ff[gi] <= en_ff[gi] & ~nxt_en[gi];
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          eob_ff[gi] <= RST_EOB;
        end else begin
          eob_ff[gi] <= nxt_eob[gi];
        end
      end

      if (gi < TX_CHANS) begin : g_tx
        assign dir_irq = tx_eob_irq;
      end else begin : g_rx
        assign dir_irq = rx_eob_irq;
      end

      en_set_a: assert property (set_v[gi] && !clr_v[gi] &&
        !err_v[gi] |=> en_ff[gi]) else $error("set did not enable");
      en_clr_a: assert property (clr_v[gi] && en_ff[gi]
        |=> !en_ff[gi] && rewind_ff[gi]) else $error("clear failed");
      err_stop_a: assert property (err_v[gi] ##1 1'b1
        |-> !en_ff[gi]) else $error("error left channel on");
      pkt_abort_a: assert property (abort_ff[gi]
        |-> $past(en_ff[gi]) && !en_ff[gi] && $past(xfer_v[gi]))
        else $error("bad abort");
      desc_rewind_a: assert property (en_ff[gi] && !nxt_en[gi]
        |=> rewind_ff[gi] ##1 !rewind_ff[gi] || !en_ff[gi])
        else $error("rewind missing");
      svc_gate_a: assert property (!en_ff[gi] |-> !grant_v[gi])
        else $error("disabled channel granted");
      eob_set_a: assert property (done_v[gi] && alert_v[gi]
        |=> eob_ff[gi] && dir_irq) else $error("alert not flagged");
      eop_set_a: assert property (done_v[gi] && last_v[gi] &&
        !backed_v[gi] && end_of_packet_irq_enable_ff |=> eob_ff[gi])
        else $error("end of packet not flagged");
      backed_up_a: assert property (done_v[gi] && last_v[gi] &&
        backed_v[gi] && !alert_v[gi] && !bad_v[gi] && !eob_ff[gi]
        |=> !eob_ff[gi]) else $error("backed-up packet flagged");
      eob_hold_a: assert property (eob_ff[gi] && !eob_clr_v[gi]
        |=> eob_ff[gi] [*1] ##0 dir_irq)
        else $error("status bit lost");
      bad_pkt_a: assert property (bad_v[gi] |=> eob_ff[gi])
        else $error("bad packet not flagged");

      en_cycle_c: cover property (set_v[gi] ##[1:20] clr_v[gi]);
      abort_c: cover property (xfer_v[gi] && en_ff[gi] && err_v[gi]);
      eob_clr_c: cover property (eob_ff[gi] ##1 eob_clr_v[gi]
        ##1 !eob_ff[gi]);
    end
  endgenerate

  assign tx_svc_grant = grant_v[TX_CHANS-1:0];
  assign rx_svc_grant = grant_v[NCH-1:TX_CHANS];
  assign tx_chan_active = en_ff[TX_CHANS-1:0];
  assign rx_chan_active = en_ff[NCH-1:TX_CHANS];
  assign tx_pkt_abort = abort_ff[TX_CHANS-1:0];
  assign rx_pkt_abort = abort_ff[NCH-1:TX_CHANS];
  assign tx_desc_rewind = rewind_ff[TX_CHANS-1:0];
  assign rx_desc_rewind = rewind_ff[NCH-1:TX_CHANS];
  assign tx_eob_irq = |eob_ff[TX_CHANS-1:0];
  assign rx_eob_irq = |eob_ff[NCH-1:TX_CHANS];

  // axi4-lite read: one-cycle answer, no read side effects
  assign s_axi_arready = !rvalid_ff;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[IDX_MSB:IDX_LSB];

  always_comb begin
    nxt_rdata = RST_RDATA;
    nxt_rerr = 1'b0;
    if (rd_idx == OFF_TX_EN_SET[IDX_MSB:IDX_LSB] ||
        rd_idx == OFF_TX_EN_CLR[IDX_MSB:IDX_LSB]) begin
      nxt_rdata[CH_FIELD_LSB +: TX_CHANS] = en_ff[TX_CHANS-1:0];
    end else if (rd_idx == OFF_RX_EN_SET[IDX_MSB:IDX_LSB] ||
                 rd_idx == OFF_RX_EN_CLR[IDX_MSB:IDX_LSB]) begin
      nxt_rdata[CH_FIELD_LSB +: RX_CHANS] = en_ff[NCH-1:TX_CHANS];
    end else if (rd_idx == OFF_TX_EOB[IDX_MSB:IDX_LSB]) begin
      nxt_rdata[CH_FIELD_LSB +: TX_CHANS] = eob_ff[TX_CHANS-1:0];
    end else if (rd_idx == OFF_RX_EOB[IDX_MSB:IDX_LSB]) begin
      nxt_rdata[CH_FIELD_LSB +: RX_CHANS] = eob_ff[NCH-1:TX_CHANS];
    end else if (rd_idx == OFF_CFG[IDX_MSB:IDX_LSB]) begin
      nxt_rdata[CFG_END_OF_PACKET_IRQ_ENABLE_BIT] = end_of_packet_irq_enable_ff;
    end else begin
      nxt_rerr = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= RST_RDATA;
      rresp_ff <= DCEOB_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rerr ? DCEOB_RESP_SLVERR : DCEOB_RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  bresp_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_resv_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[DATA_W-1:CFG_END_OF_PACKET_IRQ_ENABLE_BIT+1] == '0)
    else $error("reserved bits nonzero");
  wr_resp_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
    s_axi_awvalid && s_axi_wvalid ##[1:4] s_axi_bvalid);

endmodule

// >>> rtl/dceob_pkg.sv
// constants for the channel enable and end-of-buffer status block
package dceob_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_TX_EN_SET = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_TX_EN_CLR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RX_EN_SET = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RX_EN_CLR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_TX_EOB = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RX_EOB = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h18;

  // word index field of an address
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = ADDR_W - 1;

  // field positions
  localparam int CH_FIELD_LSB = 0;
  localparam int CH_LANE = 0;
  localparam int CFG_END_OF_PACKET_IRQ_ENABLE_BIT = 29;
  localparam int CFG_END_OF_PACKET_IRQ_ENABLE_LANE = CFG_END_OF_PACKET_IRQ_ENABLE_BIT / 8;

  // reset values
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_EOB = 1'b0;
  localparam logic RST_END_OF_PACKET_IRQ_ENABLE = 1'b0;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

  // default and maximum channel counts
  localparam int TX_CHANS_DEF = 2;
  localparam int RX_CHANS_DEF = 1;
  localparam int MAX_CHANS_DIR = 8;

  // bus response codes
  typedef enum logic [1:0] {
    DCEOB_RESP_OKAY = 2'b00,
    DCEOB_RESP_SLVERR = 2'b10
  } dceob_resp_t;

endpackage

// >>> verification/dceob_chan_model.sv
// channel-side model driving service levels and completion events
`timescale 1ns/1ps
module dceob_chan_model #(
  parameter int TX_CHANS = 2,
  parameter int RX_CHANS = 1
) (
  input wire logic clk_sys,
  output logic [TX_CHANS-1:0] tx_svc_req,
  output logic [TX_CHANS-1:0] tx_xfer_active,
  output logic [TX_CHANS-1:0] tx_err_ind,
  output logic [TX_CHANS-1:0] tx_buf_done,
  output logic [TX_CHANS-1:0] tx_buf_alert,
  output logic [TX_CHANS-1:0] tx_last_buf,
  output logic [TX_CHANS-1:0] tx_backed_up,
  output logic [TX_CHANS-1:0] tx_bad_pkt,
  output logic [RX_CHANS-1:0] rx_svc_req,
  output logic [RX_CHANS-1:0] rx_xfer_active,
  output logic [RX_CHANS-1:0] rx_err_ind,
  output logic [RX_CHANS-1:0] rx_buf_done,
  output logic [RX_CHANS-1:0] rx_buf_alert,
  output logic [RX_CHANS-1:0] rx_last_buf,
  output logic [RX_CHANS-1:0] rx_backed_up,
  output logic [RX_CHANS-1:0] rx_bad_pkt
);
  initial begin
    {tx_svc_req, tx_xfer_active, tx_err_ind, tx_buf_done} = '0;
    {tx_buf_alert, tx_last_buf, tx_backed_up, tx_bad_pkt} = '0;
    {rx_svc_req, rx_xfer_active, rx_err_ind, rx_buf_done} = '0;
    {rx_buf_alert, rx_last_buf, rx_backed_up, rx_bad_pkt} = '0;
  end
  // service request and mid-packet levels
  task automatic lvl(input logic [7:0] svc, input logic [7:0] act,
                     input logic rsvc);
    tx_svc_req <= svc[TX_CHANS-1:0];
    tx_xfer_active <= act[TX_CHANS-1:0];
    rx_svc_req <= {RX_CHANS{rsvc}};
  endtask
  // one-cycle event; k = {err, done, alert, last, backed, bad}
  task automatic ev(input bit rx, input logic [5:0] k, input logic [7:0] m);
    if (rx) begin
      rx_err_ind <= m[RX_CHANS-1:0] & {RX_CHANS{k[5]}};
      rx_buf_done <= m[RX_CHANS-1:0] & {RX_CHANS{k[4]}};
      rx_buf_alert <= m[RX_CHANS-1:0] & {RX_CHANS{k[3]}};
      rx_last_buf <= m[RX_CHANS-1:0] & {RX_CHANS{k[2]}};
      rx_backed_up <= m[RX_CHANS-1:0] & {RX_CHANS{k[1]}};
      rx_bad_pkt <= m[RX_CHANS-1:0] & {RX_CHANS{k[0]}};
    end else begin
      tx_err_ind <= m[TX_CHANS-1:0] & {TX_CHANS{k[5]}};
      tx_buf_done <= m[TX_CHANS-1:0] & {TX_CHANS{k[4]}};
      tx_buf_alert <= m[TX_CHANS-1:0] & {TX_CHANS{k[3]}};
      tx_last_buf <= m[TX_CHANS-1:0] & {TX_CHANS{k[2]}};
      tx_backed_up <= m[TX_CHANS-1:0] & {TX_CHANS{k[1]}};
      tx_bad_pkt <= m[TX_CHANS-1:0] & {TX_CHANS{k[0]}};
    end
    @(posedge clk_sys);
    {tx_err_ind, tx_buf_done, tx_bad_pkt} <= '0;
    {rx_err_ind, rx_buf_done, rx_bad_pkt} <= '0;
    // qualifiers past their hold time show the inverse, not the old value
    tx_buf_alert <= ~tx_buf_alert;
    tx_last_buf <= ~tx_last_buf;
    tx_backed_up <= ~tx_backed_up;
    rx_buf_alert <= ~rx_buf_alert;
    rx_last_buf <= ~rx_last_buf;
    rx_backed_up <= ~rx_backed_up;
    @(posedge clk_sys);
  endtask
endmodule

// >>> verification/tb.sv
// self-checking bench for the channel enable and end-of-buffer block
`timescale 1ns/1ps
module tb;
  import dceob_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [STRB_W-1:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [1:0] tx_svc_req, tx_xfer_active, tx_err_ind, tx_buf_done;
  logic [1:0] tx_buf_alert, tx_last_buf, tx_backed_up, tx_bad_pkt;
  logic [0:0] rx_svc_req, rx_xfer_active, rx_err_ind, rx_buf_done;
  logic [0:0] rx_buf_alert, rx_last_buf, rx_backed_up, rx_bad_pkt;
  logic [1:0] tx_svc_grant, tx_chan_active, tx_pkt_abort, tx_desc_rewind;
  logic [0:0] rx_svc_grant, rx_chan_active, rx_pkt_abort, rx_desc_rewind;
  logic eop_irq_enable, tx_eob_irq, rx_eob_irq;
  logic [2:0] ab_seen = '0, rw_seen = '0;
  int n_mismatch = 0;
  int checks_done = 0;

  dceob_top #(.TX_CHANS(2), .RX_CHANS(1)) u_dut (
    .clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_svc_req, .tx_xfer_active, .tx_err_ind, .tx_buf_done,
    .tx_buf_alert, .tx_last_buf, .tx_backed_up, .tx_bad_pkt,
    .rx_svc_req, .rx_xfer_active, .rx_err_ind, .rx_buf_done,
    .rx_buf_alert, .rx_last_buf, .rx_backed_up, .rx_bad_pkt,
    .tx_svc_grant, .tx_chan_active, .tx_pkt_abort, .tx_desc_rewind,
    .rx_svc_grant, .rx_chan_active, .rx_pkt_abort, .rx_desc_rewind,
    .eop_irq_enable, .tx_eob_irq, .rx_eob_irq
  );

  dceob_chan_model #(.TX_CHANS(2), .RX_CHANS(1)) u_ctl (
    .clk_sys, .tx_svc_req, .tx_xfer_active, .tx_err_ind, .tx_buf_done,
    .tx_buf_alert, .tx_last_buf, .tx_backed_up, .tx_bad_pkt,
    .rx_svc_req, .rx_xfer_active, .rx_err_ind, .rx_buf_done,
    .rx_buf_alert, .rx_last_buf, .rx_backed_up, .rx_bad_pkt
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // sticky record of abort and rewind pulses, receive channel on top
  always @(posedge clk_sys) begin
    ab_seen <= ab_seen | {rx_pkt_abort, tx_pkt_abort};
    rw_seen <= rw_seen | {rx_desc_rewind, tx_desc_rewind};
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic guard(input int n);
    if (n > 50) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      guard(++n);
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      guard(++n);
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
    @(posedge clk_sys);
  endtask

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
  endtask

  initial begin
    do_reset();
    for (int i = 0; i < 7; i++) rd(8'(4 * i), '0, 2'b00); // zero
    chk({tx_chan_active, rx_chan_active}, '0);
    chk({tx_eob_irq, rx_eob_irq}, '0);
    $display("test reset values done");
    u_ctl.lvl(8'h03, 8'h02, 1'b1); // busy ch1
    @(posedge clk_sys);
    chk(tx_svc_grant, 2'b00); // disabled ignored
    wr(OFF_TX_EN_SET, 32'hffff_ffff, 4'hf, 2'b00); // both on
    rd(OFF_TX_EN_SET, 32'h0000_0003, 2'b00); // reserved zero
    rd(OFF_TX_EN_CLR, 32'h0000_0003, 2'b00); // state
    chk(tx_svc_grant, 2'b11); // granted
    chk(tx_chan_active, 2'b11); // active out
    wr(OFF_TX_EN_CLR, 32'h0000_0002, 4'hf, 2'b00); // ch1 off
    rd(OFF_TX_EN_SET, 32'h0000_0001, 2'b00); // bit0 is ch0
    chk(tx_svc_grant, 2'b01); // ch1 ignored
    chk(ab_seen, 3'b010); // busy ch1 aborted
    chk(rw_seen, 3'b010); // ch1 rewound
    u_ctl.ev(1'b0, 6'b100000, 8'h01); // ch0 error
    rd(OFF_TX_EN_CLR, 32'h0000_0000, 2'b00); // error disables
    chk(rw_seen, 3'b011); // ch0 rewound
    chk(ab_seen, 3'b010); // idle ch0 no abort
    $display("test tx enable done");
    wr(OFF_RX_EN_SET, 32'hffff_ffff, 4'hf, 2'b00); // rx on
    rd(OFF_RX_EN_CLR, 32'h0000_0001, 2'b00); // one channel
    chk(rx_svc_grant, 1'b1); // granted
    chk(rx_chan_active, 1'b1); // active out
    wr(OFF_RX_EN_CLR, 32'hffff_fffe, 4'hf, 2'b00); // zeros
    rd(OFF_RX_EN_SET, 32'h0000_0001, 2'b00); // zeros no effect
    wr(OFF_RX_EN_CLR, 32'h0000_0001, 4'hf, 2'b00); // rx off
    rd(OFF_RX_EN_SET, 32'h0000_0000, 2'b00); // rx off
    chk(rw_seen, 3'b111); // rx rewound
    chk(ab_seen, 3'b010); // idle rx no abort
    $display("test rx enable done");
    u_ctl.ev(1'b0, 6'b011000, 8'h02); // ch1 alert
    u_ctl.ev(1'b0, 6'b010100, 8'h01); // eop, enable off
    rd(OFF_TX_EOB, 32'h0000_0002, 2'b00); // alert only
    chk(tx_eob_irq, 1'b1); // irq up
    wr(OFF_CFG, 32'h2000_0000, 4'h8, 2'b00); // enable on
    rd(OFF_CFG, 32'h2000_0000, 2'b00); // bit 29
    chk(eop_irq_enable, 1'b1); // enable out
    u_ctl.ev(1'b0, 6'b010110, 8'h01); // backed up
    rd(OFF_TX_EOB, 32'h0000_0002, 2'b00); // backed up ignored
    u_ctl.ev(1'b0, 6'b010100, 8'h01); // eop
    rd(OFF_TX_EOB, 32'h0000_0003, 2'b00); // end of packet
    wr(OFF_TX_EOB, 32'h0000_0000, 4'hf, 2'b00); // zeros
    rd(OFF_TX_EOB, 32'h0000_0003, 2'b00); // zeros kept
    wr(OFF_TX_EOB, 32'h0000_0001, 4'hf, 2'b00); // clear ch0
    rd(OFF_TX_EOB, 32'h0000_0002, 2'b00); // ch0 cleared
    wr(OFF_TX_EOB, 32'h0000_0002, 4'hf, 2'b00); // clear ch1
    chk(tx_eob_irq, 1'b0); // irq down
    u_ctl.ev(1'b1, 6'b000001, 8'h01); // rx bad packet
    rd(OFF_RX_EOB, 32'h0000_0001, 2'b00); // rx bad packet
    rd(OFF_TX_EOB, 32'h0000_0000, 2'b00); // separate
    chk({rx_eob_irq, tx_eob_irq}, 2'b10); // rx only
    u_ctl.ev(1'b0, 6'b000001, 8'h02); // tx bad packet
    rd(OFF_TX_EOB, 32'h0000_0002, 2'b00); // tx bad packet
    $display("test end of buffer done");
    wr(8'h1c, 32'hffff_ffff, 4'hf, 2'b10); // unmapped write refused
    rd(8'h1c, 32'h0000_0000, 2'b10); // unmapped read refused
    wr(OFF_TX_EN_SET, 32'h0000_0003, 4'he, 2'b00); // lane 0 off
    rd(OFF_TX_EN_SET, 32'h0000_0000, 2'b00); // untouched
    wr(OFF_TX_EN_SET, 32'h0000_0003, 4'hf, 2'b00); // both on
    chk(tx_chan_active, 2'b11); // on before reset
    do_reset();
    rd(OFF_TX_EN_SET, 32'h0000_0000, 2'b00); // cleared
    rd(OFF_TX_EOB, 32'h0000_0000, 2'b00); // cleared
    rd(OFF_RX_EOB, 32'h0000_0000, 2'b00); // cleared
    chk(eop_irq_enable, 1'b0); // cleared
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
